// [verilog/osfm_pkg.sv]
package osfm_pkg;
   // Register offsets of the multiplier bytes
   localparam logic [7:0] REG_FRAC_B0 = 8'h05;
   localparam logic [7:0] REG_FRAC_B1 = 8'h06;
   localparam logic [7:0] REG_FRAC_B2 = 8'h07;
   localparam logic [7:0] REG_INT_LO = 8'h08;
   localparam logic [7:0] REG_INT_HI = 8'h09;
   // Multiplier layout: integer 9 bits, fraction 29 bits
   localparam int MULT_INT_W = 9;
   localparam int MULT_FRAC_W = 29;
   localparam int MULT_W = MULT_INT_W + MULT_FRAC_W;
   localparam int INT_LO_BITS = 3;
   localparam int FRAC_HI_BITS = 5;
   localparam int INT_HI_BITS = 6;
   // Bus address on the serial port, arbitrary value
   localparam logic [6:0] DEV_ADDR = 7'h55;
   // Factory start-up multiplier (74 + 0x097C65D3 / 2^29)
   localparam logic [37:0] RESET_MULT = 38'h09497C65D3;
   // Legal multiplier window, same fixed point
   localparam logic [37:0] MULT_MIN = 38'h08214D0215;
   localparam logic [37:0] MULT_MAX = 38'h09C590400A;
   // Crystal and VCO limits in Hz
   localparam logic [31:0] XO_HZ = 32'h01E7F9E0;
   localparam logic [31:0] VCO_MIN_HZ = 32'h7BFA4800;
   localparam logic [31:0] VCO_MAX_HZ = 32'h9502F900;
   // Settling after a small retune
   localparam int CLK_MHZ = 40;
   localparam int SETTLE_US = 100;
   localparam logic [11:0] SETTLE_CYCLES = 12'(SETTLE_US * CLK_MHZ);
   // Serial divider length
   localparam logic [5:0] DIV_STEPS = 6'h20;
   // Serial-port slave states
   typedef enum logic [2:0] {
      OSFM_IDLE, OSFM_ADDR, OSFM_ACK_ADDR, OSFM_WDATA, OSFM_ACK_WR, OSFM_RDATA, OSFM_ACK_RD
   } osfm_state_t;
endpackage : osfm_pkg

// [verilog/osfm_divider.sv]
`timescale 1ns/10ps
`default_nettype none
module osfm_divider (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [9:0] divisor,
   output logic [31:0] quotient,
   output logic busy
);
   import osfm_pkg::*;

   logic [31:0] dvd;
   logic [10:0] rem;
   logic [5:0] steps;
   logic [10:0] trial;

   // One quotient bit per clock, restoring style
   assign trial = {rem[9:0], dvd[31]};

   // Sequencer; a restart abandons any division in flight
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         dvd <= 32'h00000000;
         rem <= 11'h000;
         steps <= 6'h00;
         busy <= 1'b0;
         quotient <= 32'h00000000;
      end else if (start) begin
         dvd <= dividend;
         rem <= 11'h000;
         steps <= DIV_STEPS;
         busy <= (divisor != 10'h000);
         quotient <= 32'h00000000; // Zero divisor gives zero, no hang
      end else if (busy) begin
         dvd <= {dvd[30:0], (trial >= {1'b0, divisor})};
         rem <= (trial >= {1'b0, divisor}) ? trial - {1'b0, divisor} : trial;
         steps <= steps - 6'h01;
         if (steps == 6'h01) begin
            busy <= 1'b0;
            quotient <= {dvd[30:0], (trial >= {1'b0, divisor})};
         end
      end
   end
endmodule : osfm_divider
`default_nettype wire

// [verilog/osfm_top.sv]
`timescale 1ns/10ps
`default_nettype none
module osfm_top (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   input wire logic [9:0] high_speed_divider,
   input wire logic [2:0] low_speed_divider,
   output logic [osfm_pkg::MULT_W-1:0] synth_mult,
   output logic [31:0] vco_frequency,
   output logic [31:0] out_freq_hz,
   output logic freq_valid,
   output logic freq_settled,
   output logic mult_in_range,
   output logic vco_in_range,
   output logic update_pending
);
   import osfm_pkg::*;

   osfm_state_t state;
   logic scl_prev, sda_prev, start_cond, stop_cond, scl_rise, scl_fall, byte_done;
   logic first_byte, is_read, master_ack, wr_stb, commit;
   logic calc_start, calc_arm, div_busy, div_busy_prev;
   logic [3:0] bit_cnt;
   logic [7:0] shift_in, shift_out, pointer, wr_addr, wr_data, rd_data;
   logic [7:0] stage_b0, stage_b1, stage_b2, stage_b3;
   logic [11:0] settle_cnt;
   logic [62:0] vco_product;
   logic [31:0] div_quot;

   // Bus edges; pins are already in the clock domain
   assign start_cond = scl && sda_prev && !sda_in;
   assign stop_cond = scl && !sda_prev && sda_in;
   assign scl_rise = scl && !scl_prev;
   assign scl_fall = !scl && scl_prev;
   assign byte_done = scl_fall && (bit_cnt == 4'h8);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl;
         sda_prev <= sda_in;
      end
   end

   // Open-drain: only ever pulls low, enable low while pulling
   assign sda_out = 1'b0;
   assign sda_oe_b = !((state == OSFM_ACK_ADDR) || (state == OSFM_ACK_WR) ||
                       ((state == OSFM_RDATA) && !shift_out[7]));

   // Serial-port slave: address, register pointer, then data bytes
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= OSFM_IDLE;
         bit_cnt <= 4'h0;
         shift_in <= 8'h00;
         shift_out <= 8'hFF;
         pointer <= 8'h00;
         first_byte <= 1'b0;
         is_read <= 1'b0;
         master_ack <= 1'b0;
      end else if (start_cond) begin
         state <= OSFM_ADDR; // Repeated start keeps the pointer
         bit_cnt <= 4'h0;
         shift_out <= 8'hFF;
      end else if (stop_cond) begin
         state <= OSFM_IDLE;
         shift_out <= 8'hFF;
      end else begin
         if (scl_rise && (bit_cnt != 4'h8)) begin
            shift_in <= {shift_in[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
         end
         case (state)
            OSFM_ADDR: begin
               if (byte_done) begin
                  if (shift_in[7:1] == DEV_ADDR) begin
                     state <= OSFM_ACK_ADDR;
                     is_read <= shift_in[0];
                     first_byte <= 1'b1;
                  end else begin
                     state <= OSFM_IDLE; // Not ours; wait for next start
                  end
               end
            end
            OSFM_ACK_ADDR: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (is_read) begin
                     state <= OSFM_RDATA;
                     shift_out <= rd_data;
                  end else begin
                     state <= OSFM_WDATA;
                  end
               end
            end
            OSFM_WDATA: begin
               if (byte_done) begin
                  state <= OSFM_ACK_WR;
                  first_byte <= 1'b0;
                  if (first_byte) begin
                     pointer <= shift_in;
                  end else begin
                     pointer <= pointer + 8'h01; // Burst walks 5..9 in order
                  end
               end
            end
            OSFM_ACK_WR: begin
               if (scl_fall) begin
                  state <= OSFM_WDATA;
                  bit_cnt <= 4'h0;
               end
            end
            OSFM_RDATA: begin
               if (byte_done) begin
                  state <= OSFM_ACK_RD;
                  shift_out <= 8'hFF;
                  pointer <= pointer + 8'h01;
               end else if (scl_fall) begin
                  shift_out <= {shift_out[6:0], 1'b1};
               end
            end
            OSFM_ACK_RD: begin
               if (scl_rise) begin
                  master_ack <= !sda_in;
               end
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (master_ack) begin
                     state <= OSFM_RDATA;
                     shift_out <= rd_data;
                  end else begin
                     state <= OSFM_IDLE; // Nack ends the read
                  end
               end
            end
            default: begin
               state <= OSFM_IDLE;
            end
         endcase
      end
   end

   // Register write strobe, one cycle, after the pointer byte
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wr_stb <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_stb <= (state == OSFM_WDATA) && byte_done && !first_byte && !start_cond && !stop_cond;
         wr_addr <= pointer;
         wr_data <= shift_in;
      end
   end

   assign commit = wr_stb && (wr_addr == REG_INT_HI);
   // Read map; register 9 reads the upper six live integer bits, top two read zero
   always_comb begin
      case (pointer)
         REG_FRAC_B0: rd_data = stage_b0;
         REG_FRAC_B1: rd_data = stage_b1;
         REG_FRAC_B2: rd_data = stage_b2;
         REG_INT_LO: rd_data = stage_b3;
         REG_INT_HI: rd_data = {2'b00, synth_mult[MULT_W-1 -: INT_HI_BITS]};
         default: rd_data = 8'h00;
      endcase
   end
   // Staging bytes; the synthesizer never sees a half-written value
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         stage_b0 <= RESET_MULT[7:0];
         stage_b1 <= RESET_MULT[15:8];
         stage_b2 <= RESET_MULT[23:16];
         stage_b3 <= RESET_MULT[31:24];
      end else if (wr_stb) begin
         case (wr_addr)
            REG_FRAC_B0: stage_b0 <= wr_data;
            REG_FRAC_B1: stage_b1 <= wr_data;
            REG_FRAC_B2: stage_b2 <= wr_data;
            REG_INT_LO: stage_b3 <= wr_data;
            default: ;
         endcase
      end
   end

   // Pending flag: a staged byte (registers 5..8) was written since the last commit
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         update_pending <= 1'b0;
      end else if (commit) begin
         update_pending <= 1'b0;
      end else if (wr_stb && (wr_addr >= REG_FRAC_B0) && (wr_addr < REG_INT_HI)) begin
         update_pending <= 1'b1;
      end
   end

   // Atomic transfer of all 38 bits; one step, so no mixed old/new value
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         synth_mult <= RESET_MULT;
      end else if (commit) begin
         synth_mult <= {wr_data[INT_HI_BITS-1:0], stage_b3, stage_b2, stage_b1, stage_b0};
      end
   end

   // Range flags; software is expected to stay inside, we only report
   assign mult_in_range = (synth_mult >= MULT_MIN) && (synth_mult <= MULT_MAX);
   assign vco_in_range = (vco_frequency >= VCO_MIN_HZ) && (vco_frequency <= VCO_MAX_HZ);

   // VCO = crystal x multiplier, fraction dropped after the product
   assign vco_product = 63'(XO_HZ) * 63'(synth_mult);
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         vco_frequency <= 32'h00000000;
      end else begin
         vco_frequency <= vco_product[MULT_FRAC_W +: 32];
      end
   end

   // Settle timer restarts on every commit; the output may still drift until done
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         settle_cnt <= 12'h000;
         freq_settled <= 1'b1;
      end else if (commit) begin
         settle_cnt <= SETTLE_CYCLES;
         freq_settled <= 1'b0;
      end else if (settle_cnt != 12'h000) begin
         settle_cnt <= settle_cnt - 12'h001;
         freq_settled <= (settle_cnt == 12'h001);
      end
   end

   // Recompute the output rate after reset and after each commit;
   // divider inputs are straps; low_speed_divider is read only at the start, high_speed_divider on every divide step
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         calc_arm <= 1'b1;
         calc_start <= 1'b0;
      end else begin
         calc_start <= calc_arm; // Waits one cycle for vco_frequency
         calc_arm <= commit;
      end
   end

   osfm_divider u_div (
      .clock(clock),
      .rst_b(rst_b),
      .start(calc_start),
      .dividend(vco_frequency >> low_speed_divider),
      .divisor(high_speed_divider),
      .quotient(div_quot),
      .busy(div_busy)
   );

   // Output frequency result and its valid flag
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         div_busy_prev <= 1'b0;
         out_freq_hz <= 32'h00000000;
         freq_valid <= 1'b0;
      end else begin
         div_busy_prev <= div_busy;
         if (calc_start || calc_arm) begin
            freq_valid <= 1'b0;
         end else if (!div_busy && (div_busy_prev || !freq_valid)) begin
            out_freq_hz <= div_quot;
            freq_valid <= 1'b1;
         end
      end
   end
endmodule : osfm_top
`default_nettype wire

// [verif/osfm_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module osfm_chk
   import osfm_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic sda_oe_b,
   input wire logic [9:0] high_speed_divider,
   input wire logic [2:0] low_speed_divider,
   input wire logic [osfm_pkg::MULT_W-1:0] synth_mult,
   input wire logic [31:0] vco_frequency,
   input wire logic [31:0] out_freq_hz,
   input wire logic freq_valid,
   input wire logic freq_settled,
   input wire logic mult_in_range,
   input wire logic vco_in_range,
   input wire logic update_pending
);
   logic [12:0] low_cnt;
   logic [31:0] vco_calc;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Wide product, so no high bits are lost before the shift
   assign vco_calc = 32'((72'(XO_HZ) * 72'(synth_mult)) >> 29);
   // Cycles spent unsettled since the last commit
   always_ff @(posedge clock) begin
      if (!rst_b || freq_settled) begin
         low_cnt <= 13'h0000;
      end else begin
         low_cnt <= low_cnt + 13'h0001;
      end
   end
   a_vco_follows_mult: assert property ($past(rst_b) |-> vco_frequency == $past(vco_calc))
      else $error("vco rate does not follow multiplier");
   a_out_on_valid: assert property ($rose(freq_valid) && high_speed_divider != 10'h000 |->
      out_freq_hz == (vco_frequency >> low_speed_divider) / high_speed_divider)
      else $error("output rate wrong when flagged valid");
   a_settle_exact: assert property ($rose(freq_settled) |-> low_cnt == 13'h0FA0)
      else $error("settling window not 4000 cycles");
   a_commit_clears: assert property ($changed(synth_mult) |-> !update_pending && !freq_settled)
      else $error("commit left pending or settled");
   a_commit_on_ack: assert property ($changed(synth_mult) |-> !sda_oe_b)
      else $error("multiplier moved outside a byte ack");
   a_valid_after: assert property ($changed(synth_mult) |-> ##[1:60] $rose(freq_valid))
      else $error("output rate not refreshed after commit");
   a_mult_window: assert property (mult_in_range == (synth_mult >= MULT_MIN &&
      synth_mult <= MULT_MAX))
      else $error("multiplier range flag wrong");
   a_vco_window: assert property (vco_in_range == (vco_frequency >= VCO_MIN_HZ &&
      vco_frequency <= VCO_MAX_HZ))
      else $error("vco range flag wrong");
endmodule : osfm_chk
bind osfm_top osfm_chk u_chk (.clock(clock), .rst_b(rst_b), .sda_oe_b(sda_oe_b),
   .high_speed_divider(high_speed_divider), .low_speed_divider(low_speed_divider),
   .synth_mult(synth_mult), .vco_frequency(vco_frequency), .out_freq_hz(out_freq_hz),
   .freq_valid(freq_valid), .freq_settled(freq_settled), .mult_in_range(mult_in_range),
   .vco_in_range(vco_in_range), .update_pending(update_pending));
`default_nettype wire

// [verif/osfm_host.sv]
`timescale 1ns/10ps
`default_nettype none
module osfm_host (
   input wire logic clock,
   input wire logic sda_w,
   output logic scl,
   output logic sda_h
);
   import osfm_pkg::*;
   logic ackd;
   // Idle bus: both lines released high
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   // Six clocks a phase keeps SCL well below the core rate
   task automatic ph();
      repeat (6) @(posedge clock);
      #1;
   endtask : ph
   // Data changes only while SCL is low
   task automatic bit_io(input logic b, output logic r);
      sda_h = b;
      ph();
      scl = 1'b1;
      ph();
      r = sda_w;
      scl = 1'b0;
      ph();
   endtask : bit_io
   task automatic start();
      sda_h = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sda_h = 1'b0;
      ph();
      scl = 1'b0;
      ph();
   endtask : start
   task automatic stop();
      sda_h = 1'b0;
      ph();
      scl = 1'b1;
      ph();
      sda_h = 1'b1;
      ph();
   endtask : stop
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(m, ackd);
   endtask : xfer
   // Pointer then data bytes; ok only if every byte was acked
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$],
                     output logic ok);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, 1'b1, q);
      ok = !ackd;
      xfer(p, 1'b1, q);
      ok = ok & !ackd;
      foreach (d[i]) begin
         xfer(d[i], 1'b1, q);
         ok = ok & !ackd;
      end
      stop();
   endtask : wr
   // Pointer write, repeated start, then n bytes; nack ends the burst
   task automatic rd(input logic [7:0] p, input int n, output logic [7:0] d[$]);
      logic [7:0] q;
      d = {};
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, q);
      xfer(p, 1'b1, q);
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, q);
         d.push_back(q);
      end
      stop();
   endtask : rd
endmodule : osfm_host
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   import osfm_pkg::*;
   logic clock, rst_b, scl, sda_h, sda_w, sda_out, sda_oe_b, ok;
   logic freq_valid, freq_settled, mult_in_range, vco_in_range, update_pending;
   logic [9:0] hs;
   logic [2:0] ls;
   logic [MULT_W-1:0] synth_mult, prev;
   logic [31:0] vco_frequency, out_freq_hz, seed;
   logic [7:0] q[$];
   int n_mismatch, checks_done;
   // Open drain with pull-up: either side may pull low
   assign sda_w = sda_h & (sda_oe_b | sda_out);
   osfm_top u_dut (.clock(clock), .rst_b(rst_b), .scl(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_b(sda_oe_b), .high_speed_divider(hs),
      .low_speed_divider(ls), .synth_mult(synth_mult), .vco_frequency(vco_frequency),
      .out_freq_hz(out_freq_hz), .freq_valid(freq_valid), .freq_settled(freq_settled),
      .mult_in_range(mult_in_range), .vco_in_range(vco_in_range),
      .update_pending(update_pending));
   osfm_host u_host (.clock(clock), .sda_w(sda_w), .scl(scl), .sda_h(sda_h));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [31:0] vco_of(input logic [37:0] mv);
      return 32'((72'(XO_HZ) * 72'(mv)) >> 29);
   endfunction : vco_of
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk
   // Bounded wait on valid (w=1) or settled (w=0)
   task automatic wt(input logic w);
      int k;
      for (k = 0; k < 5000; k++) begin
         if ((w ? freq_valid : freq_settled) === 1'b1) break;
         @(posedge clock);
         #1;
      end
      if (k == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wt
   // Stage bytes, read them back, then commit with the top byte
   task automatic prog(input logic [37:0] mv);
      prev = synth_mult;
      q = {mv[7:0], mv[15:8], mv[23:16], mv[31:24]};
      u_host.wr(DEV_ADDR, REG_FRAC_B0, q, ok);
      chk(ok, 1'b1);
      chk(synth_mult, prev);
      chk(update_pending, 1'b1);
      u_host.rd(REG_FRAC_B0, 4, q);
      foreach (q[i]) begin
         chk(q[i], mv[8*i +: 8]);
      end
      wt(1'b0);
      q = {{2'b00, mv[37:32]}};
      u_host.wr(DEV_ADDR, REG_INT_HI, q, ok);
      chk(synth_mult, mv);
      chk(update_pending, 1'b0);
      chk(freq_settled, 1'b0);
      wt(1'b1);
      chk(vco_frequency, vco_of(mv));
      chk(out_freq_hz, (vco_of(mv) >> ls) / hs);
      chk({mult_in_range, vco_in_range}, 2'b11);
   endtask : prog
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      rst_b = 1'b0;
      seed = 32'h00016742;
      hs = 10'h010;
      ls = 3'h0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (2) @(posedge clock);
      #1;
      rst_b = 1'b1;
      chk(synth_mult, RESET_MULT);
      wt(1'b1);
      chk(out_freq_hz, (vco_of(RESET_MULT) >> ls) / hs);
      u_host.rd(REG_FRAC_B0, 5, q);
      chk({q[4], q[3], q[2], q[1], q[0]}, 40'(RESET_MULT));
      chk({sda_out, sda_oe_b}, 2'b01);
      $display("test reset done");
      prog({9'h04A, 29'h071DCF85});
      $display("test example retune done");
      // Offsets stay within a quarter of the small-change window
      // Straps move only between updates, never while a division runs
      for (int i = 0; i < 4; i++) begin
         hs = 10'(xs() % 32'h000003F5) + 10'h00A;
         ls = 3'(xs() % 32'h00000006);
         prog(RESET_MULT + 38'(xs() & 32'h00FFFFFF) - 38'h00800000);
      end
      $display("test random retunes done");
      prev = synth_mult;
      q = {8'h05};
      u_host.wr(7'h54, REG_INT_HI, q, ok);
      chk(ok, 1'b0);
      chk(synth_mult, prev);
      $display("test foreign address done");
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
